// >>> gpfl_panel.v
`include "gpfl_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module gpfl_panel #(
  parameter CNT_W = `GPFL_ONSET_CNT_W,
  parameter [CNT_W-1:0] SHORT_ONSET_CYCLES =
    `GPFL_ONSET_SHORT_MS * `GPFL_CLK_KHZ,
  parameter [CNT_W-1:0] LONG_ONSET_CYCLES =
    `GPFL_ONSET_LONG_MS * `GPFL_CLK_KHZ
) (
  // Clock, reset, enable
  input wire core_clk,
  input wire arst_n,
  input wire clkEn,
  // Operator push buttons, high while pressed
  input wire glowBtn,
  input wire crankBtn,
  input wire panelOnBtn,
  input wire panelOffBtn,
  // Sensor pins, high when contact open
  input wire coolantIn,
  input wire leakIn,
  input wire lubeIn,
  input wire alternatorOutputAlarmIn,
  input wire coilIn,
  input wire chargeSenseIn,
  // Straps
  input wire glowWithCrankStrap,
  input wire [1:0] excitationSourceStrap,
  input wire coolantPolarityStrap,
  input wire leakPolarityStrap,
  input wire lubePolarityStrap,
  input wire altAlarmPolarityStrap,
  input wire coilPolarityStrap,
  input wire leakSeverityStrap,
  input wire altAlarmSeverityStrap,
  input wire chargePolarityStrapA,
  input wire chargePolarityStrapB,
  // Relay outputs
  output reg glowRelay,
  output reg fuelRelay,
  output reg crankRelay,
  output reg excitationOn,
  // Indicators
  output reg coolantRedLed,
  output reg leakRedLed,
  output reg leakYellowLed,
  output reg lubeRedLed,
  output reg altRedLed,
  output reg altYellowLed,
  output reg coilRedLed,
  output reg chargeOkLed,
  output reg chargeFaultLed,
  output reg standbyLed,
  // Register port
  input wire [`GPFL_ADDR_W-1:0] regAddr,
  input wire [`GPFL_DATA_W-1:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [`GPFL_DATA_W-1:0] regRdata,
  // Interrupt
  output wire irq
);

  localparam NSYNC = 10;
  localparam S_GLOW = 0;
  localparam S_CRANK = 1;
  localparam S_ON = 2;
  localparam S_OFF = 3;
  localparam S_COOL = 4;
  localparam S_LEAK = 5;
  localparam S_LUBE = 6;
  localparam S_ALT = 7;
  localparam S_COIL = 8;
  localparam S_CHG = 9;

  // Two-stage synchroniser; stage one feeds only stage two
  reg [NSYNC-1:0] syncA_q;
  reg [NSYNC-1:0] syncB_q;
  wire [NSYNC-1:0] rawPins;

  assign rawPins = {chargeSenseIn, coilIn, alternatorOutputAlarmIn,
                    lubeIn, leakIn, coolantIn, panelOffBtn, panelOnBtn,
                    crankBtn, glowBtn};

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_q <= {NSYNC{1'b0}};
      syncB_q <= {NSYNC{1'b0}};
    end else if (clkEn) begin
      syncA_q <= rawPins;
      syncB_q <= syncA_q;
    end
  end

  // Panel on/off latch; off wins when both are pressed
  reg panelOn_q;
  wire panelOn_d;

  assign panelOn_d = syncB_q[S_OFF] ? 1'b0 :
                     (syncB_q[S_ON] ? 1'b1 : panelOn_q);

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      panelOn_q <= 1'b0;
    end else if (clkEn) begin
      panelOn_q <= panelOn_d;
    end
  end

  // Raw error levels after polarity straps
  wire coolantRaw;
  wire leakRaw;
  wire lubeRaw;
  wire altRaw;
  wire coilRaw;

  // Strap low (1-2): open contact (pin high) is the error
  // Strap high (2-3): contact closed to ground (pin low) is the error
  assign coolantRaw = syncB_q[S_COOL] ^ coolantPolarityStrap;
  assign leakRaw = syncB_q[S_LEAK] ^ leakPolarityStrap;
  assign lubeRaw = syncB_q[S_LUBE] ^ lubePolarityStrap;
  assign altRaw = syncB_q[S_ALT] ^ altAlarmPolarityStrap;
  assign coilRaw = syncB_q[S_COIL] ^ coilPolarityStrap;

  // Onset qualifiers; filters are held clear while the panel is off
  wire panelOff;
  wire coolantErr;
  wire leakErr;
  wire lubeErr;
  wire altErr;
  wire coilErr;

  assign panelOff = !panelOn_q;

  gpfl_onset_filter #(
    .CNT_W(CNT_W),
    .ONSET_CYCLES(SHORT_ONSET_CYCLES)
  ) coolantFilter (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .clear(panelOff),
    .rawErr(coolantRaw),
    .errQ(coolantErr)
  );

  gpfl_onset_filter #(
    .CNT_W(CNT_W),
    .ONSET_CYCLES(SHORT_ONSET_CYCLES)
  ) leakFilter (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .clear(panelOff),
    .rawErr(leakRaw),
    .errQ(leakErr)
  );

  gpfl_onset_filter #(
    .CNT_W(CNT_W),
    .ONSET_CYCLES(LONG_ONSET_CYCLES)
  ) lubeFilter (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .clear(panelOff),
    .rawErr(lubeRaw),
    .errQ(lubeErr)
  );

  gpfl_onset_filter #(
    .CNT_W(CNT_W),
    .ONSET_CYCLES(SHORT_ONSET_CYCLES)
  ) altFilter (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .clear(panelOff),
    .rawErr(altRaw),
    .errQ(altErr)
  );

  gpfl_onset_filter #(
    .CNT_W(CNT_W),
    .ONSET_CYCLES(SHORT_ONSET_CYCLES)
  ) coilFilter (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .clear(panelOff),
    .rawErr(coilRaw),
    .errQ(coilErr)
  );

  // Severity: strap high turns the input into a warning only
  wire leakStops;
  wire altStops;
  wire shutdownFault;

  assign leakStops = leakErr && !leakSeverityStrap;
  assign altStops = altErr && !altAlarmSeverityStrap;
  assign shutdownFault = coolantErr || lubeErr || coilErr ||
                         leakStops || altStops;

  // Charge sense: strap high (2-3) means healthy when pin is high
  wire chargeHealthy;
  wire chargeFault;
  wire strapMismatch;

  assign chargeHealthy = !(syncB_q[S_CHG] ^ chargePolarityStrapA);
  assign chargeFault = panelOn_q && !chargeHealthy;
  // Both charge straps must agree; strap A decides, B is only checked
  assign strapMismatch = chargePolarityStrapA ^ chargePolarityStrapB;

  // Next relay states; everything idle while the panel is off
  wire glow_d;
  wire fuel_d;
  wire crank_d;
  reg excite_d;

  assign glow_d = panelOn_q && (syncB_q[S_GLOW] ||
                  (glowWithCrankStrap && syncB_q[S_CRANK]));
  assign fuel_d = panelOn_q && (syncB_q[S_CRANK] ||
                  !shutdownFault);
  assign crank_d = panelOn_q && syncB_q[S_CRANK];

  always @* begin
    case (excitationSourceStrap)
      `GPFL_EXC_FUEL: excite_d = fuel_d;
      `GPFL_EXC_PANEL: excite_d = panelOn_q;
      default: excite_d = 1'b0;
    endcase
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      glowRelay <= 1'b0;
      fuelRelay <= 1'b0;
      crankRelay <= 1'b0;
      excitationOn <= 1'b0;
      coolantRedLed <= 1'b0;
      leakRedLed <= 1'b0;
      leakYellowLed <= 1'b0;
      lubeRedLed <= 1'b0;
      altRedLed <= 1'b0;
      altYellowLed <= 1'b0;
      coilRedLed <= 1'b0;
      chargeOkLed <= 1'b0;
      chargeFaultLed <= 1'b0;
      standbyLed <= 1'b0;
    end else if (clkEn) begin
      glowRelay <= glow_d;
      fuelRelay <= fuel_d;
      crankRelay <= crank_d;
      excitationOn <= excite_d;
      coolantRedLed <= coolantErr;
      leakRedLed <= leakErr && !leakSeverityStrap;
      leakYellowLed <= leakErr && leakSeverityStrap;
      lubeRedLed <= lubeErr;
      altRedLed <= altErr && !altAlarmSeverityStrap;
      altYellowLed <= altErr && altAlarmSeverityStrap;
      coilRedLed <= coilErr;
      chargeOkLed <= panelOn_q && chargeHealthy;
      chargeFaultLed <= chargeFault;
      standbyLed <= panelOn_q;
    end
  end

  // Event capture: rising edge of each qualified condition
  wire [`GPFL_EVT_W-1:0] evtLevel;
  reg [`GPFL_EVT_W-1:0] evtPrev_q;
  wire [`GPFL_EVT_W-1:0] evtRise;

  assign evtLevel = {chargeFault, coilErr, altErr, lubeErr, leakErr,
                     coolantErr};
  assign evtRise = evtLevel & ~evtPrev_q;

  // Status and mask registers
  reg [`GPFL_EVT_W-1:0] status_q;
  reg [`GPFL_EVT_W-1:0] mask_q;
  wire [`GPFL_EVT_W-1:0] status_d;
  wire wrStatus;
  wire wrMask;
  wire [`GPFL_EVT_W-1:0] clrBits;

  assign wrStatus = regWr && (regAddr == `GPFL_OFS_STATUS);
  assign wrMask = regWr && (regAddr == `GPFL_OFS_MASK);
  assign clrBits = wrStatus ? regWdata[`GPFL_EVT_W-1:0] :
                   {`GPFL_EVT_W{1'b0}};
  // A new event in the clearing cycle survives the clear
  assign status_d = (status_q & ~clrBits) | evtRise;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      evtPrev_q <= {`GPFL_EVT_W{1'b0}};
      status_q <= `GPFL_RST_STATUS;
      mask_q <= `GPFL_RST_MASK;
    end else if (clkEn) begin
      evtPrev_q <= evtLevel;
      status_q <= status_d;
      if (wrMask) begin
        mask_q <= regWdata[`GPFL_EVT_W-1:0];
      end
    end
  end

  assign irq = |(status_q & mask_q);

  // Live view of the panel state
  wire [`GPFL_DATA_W-1:0] liveWord;

  assign liveWord = {4'h0, strapMismatch, panelOn_q, excitationOn,
                     glowRelay, crankRelay, fuelRelay, evtLevel};

  // Read data stands for the one cycle after the read strobe
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= {`GPFL_DATA_W{1'b0}};
    end else if (clkEn) begin
      if (regRd) begin
        case (regAddr)
          `GPFL_OFS_STATUS: regRdata <= {10'h000, status_q};
          `GPFL_OFS_MASK: regRdata <= {10'h000, mask_q};
          `GPFL_OFS_LIVE: regRdata <= liveWord;
          default: regRdata <= {`GPFL_DATA_W{1'b0}};
        endcase
      end else begin
        regRdata <= {`GPFL_DATA_W{1'b0}};
      end
    end
  end

endmodule // gpfl_panel

`default_nettype wire

// >>> gpfl_regs.vh
`ifndef GPFL_REGS_VH
`define GPFL_REGS_VH

// Register byte offsets
`define GPFL_ADDR_W 4
`define GPFL_DATA_W 16
`define GPFL_OFS_STATUS 4'h0
`define GPFL_OFS_MASK 4'h4
`define GPFL_OFS_LIVE 4'h8

// Status and mask bit positions (event bits)
`define GPFL_EVT_COOLANT 0
`define GPFL_EVT_LEAK 1
`define GPFL_EVT_LUBE 2
`define GPFL_EVT_ALT 3
`define GPFL_EVT_COIL 4
`define GPFL_EVT_CHARGE 5
`define GPFL_EVT_W 6

// Live register extra bit positions
`define GPFL_LIVE_FUEL 6
`define GPFL_LIVE_CRANK 7
`define GPFL_LIVE_GLOW 8
`define GPFL_LIVE_EXCITE 9
`define GPFL_LIVE_PANEL 10
`define GPFL_LIVE_STRAPMIS 11

// Reset values
`define GPFL_RST_STATUS 6'h00
`define GPFL_RST_MASK 6'h00

// Excitation strap codes
`define GPFL_EXC_OPEN 2'h0
`define GPFL_EXC_FUEL 2'h1
`define GPFL_EXC_PANEL 2'h2

// Timing
`define GPFL_CLK_KHZ 50000
`define GPFL_ONSET_SHORT_MS 100
`define GPFL_ONSET_LONG_MS 1000
`define GPFL_ONSET_CNT_W 26

`endif

// >>> gpfl_onset_filter.v
`timescale 1ns/1ns
`default_nettype none

module gpfl_onset_filter #(
  parameter CNT_W = 26,
  parameter [CNT_W-1:0] ONSET_CYCLES = 5000000
) (
  // Clock and reset
  input wire core_clk,
  input wire arst_n,
  input wire clkEn,
  // Filter
  input wire clear,
  input wire rawErr,
  output reg errQ
);

  localparam [CNT_W-1:0] LAST = ONSET_CYCLES - {{(CNT_W-1){1'b0}}, 1'b1};

  reg [CNT_W-1:0] count_q;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= {CNT_W{1'b0}};
      errQ <= 1'b0;
    end else if (clkEn) begin
      if (clear || !rawErr) begin
        // Normal level restarts the count and drops the error at once
        count_q <= {CNT_W{1'b0}};
        errQ <= 1'b0;
      end else if (count_q == LAST) begin
        errQ <= 1'b1;
      end else begin
        count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // gpfl_onset_filter

`default_nettype wire

// >>> gpfl_panel_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
module gpfl_panel_chk #(
  parameter CNT_W = 26,
  parameter [CNT_W-1:0] SHORT_ONSET_CYCLES = 8,
  parameter [CNT_W-1:0] LONG_ONSET_CYCLES = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Buttons, pins, straps
  input wire logic glowBtn,
  input wire logic crankBtn,
  input wire logic glowWithCrankStrap,
  input wire logic coolantIn,
  input wire logic lubeIn,
  input wire logic coolantPolarityStrap,
  input wire logic lubePolarityStrap,
  input wire logic regRd,
  // Relays and indicators
  input wire logic glowRelay,
  input wire logic fuelRelay,
  input wire logic crankRelay,
  input wire logic coolantRedLed,
  input wire logic leakRedLed,
  input wire logic leakYellowLed,
  input wire logic lubeRedLed,
  input wire logic altRedLed,
  input wire logic altYellowLed,
  input wire logic coilRedLed,
  input wire logic standbyLed,
  input wire logic [15:0] regRdata
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // Relay pipeline is two sync flops plus the output flop
  crank_follow_a: assert property (
    crankRelay |-> $past(crankBtn, 3)) else $error("starter without button");
  glow_follow_a: assert property (
    glowRelay |-> $past(glowBtn || (crankBtn && glowWithCrankStrap), 3))
    else $error("glow without cause");
  fuel_bypass_a: assert property (
    crankRelay |-> fuelRelay) else $error("fuel cut while cranking");
  fuel_cut_a: assert property (
    (coolantRedLed || leakRedLed || lubeRedLed || altRedLed || coilRedLed)
    && !crankRelay |-> !fuelRelay) else $error("fuel on with red fault");
  sev_excl_a: assert property (
    !(leakRedLed && leakYellowLed) && !(altRedLed && altYellowLed))
    else $error("red and yellow together");
  off_idle_a: assert property (
    !standbyLed |-> !(glowRelay || fuelRelay || crankRelay))
    else $error("relay on while panel off");
  rdata_idle_a: assert property (
    !$past(regRd) |-> regRdata == 16'h0000) else $error("stray read data");
  coolant_onset_a: assert property (
    $rose(coolantRedLed) |->
    $past(coolantIn ^ coolantPolarityStrap, SHORT_ONSET_CYCLES))
    else $error("coolant error too early");
  lube_onset_a: assert property (
    $rose(lubeRedLed) |-> $past(lubeIn ^ lubePolarityStrap, LONG_ONSET_CYCLES))
    else $error("oil error too early");
  coolant_clear_a: assert property (
    coolantRedLed |-> $past(coolantIn ^ coolantPolarityStrap, 4))
    else $error("coolant error held too long");
endmodule // gpfl_panel_chk
bind gpfl_panel gpfl_panel_chk #(.CNT_W(CNT_W),
  .SHORT_ONSET_CYCLES(SHORT_ONSET_CYCLES),
  .LONG_ONSET_CYCLES(LONG_ONSET_CYCLES)) u_gpfl_panel_chk (
  .core_clk, .arst_n, .glowBtn, .crankBtn, .glowWithCrankStrap, .coolantIn,
  .lubeIn, .coolantPolarityStrap, .lubePolarityStrap, .regRd, .glowRelay,
  .fuelRelay, .crankRelay, .coolantRedLed, .leakRedLed, .leakYellowLed,
  .lubeRedLed, .altRedLed, .altYellowLed, .coilRedLed, .standbyLed,
  .regRdata);
`default_nettype wire

// >>> gpfl_plant.sv
`timescale 1ns/1ns
`default_nettype none
// Sensor contacts: pin high while open, a fault flips the resting contact
module gpfl_plant (
  // Fault intent and polarity straps
  input wire logic [4:0] fault,
  input wire logic [4:0] pol,
  // Sensor pins
  output logic [4:0] pins
);
  assign pins = fault ^ pol;
endmodule // gpfl_plant
`default_nettype wire

// >>> gpfl_panel_test.sv
`include "gpfl_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module gpfl_panel_test;
  localparam int SH = 8;
  localparam int LG = 20;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic glowBtn = 1'b0, crankBtn = 1'b0, panelOnBtn = 1'b0;
  logic panelOffBtn = 1'b0, chargeSenseIn = 1'b0, glowWithCrankStrap = 1'b0;
  logic [1:0] excitationSourceStrap = 2'h0;
  logic leakSeverityStrap = 1'b0, altAlarmSeverityStrap = 1'b0;
  logic chargePolarityStrapA = 1'b0, chargePolarityStrapB = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0, regRd = 1'b0, clkEn = 1'b1;
  logic [4:0] fault = 5'h00, pol = 5'h00;
  wire [4:0] pins;
  wire glowRelay, fuelRelay, crankRelay, excitationOn, coolantRedLed;
  wire leakRedLed, leakYellowLed, lubeRedLed, altRedLed, altYellowLed;
  wire coilRedLed, chargeOkLed, chargeFaultLed, standbyLed, irq;
  wire [15:0] regRdata;
  wire [4:0] red = {coilRedLed, altRedLed, lubeRedLed, leakRedLed,
    coolantRedLed};
  int error_cnt = 0, total_checks = 0, cyc = 0;
  gpfl_plant u_gpfl_plant (.fault(fault), .pol(pol), .pins(pins));
  gpfl_panel #(.SHORT_ONSET_CYCLES(SH), .LONG_ONSET_CYCLES(LG)) u_gpfl_panel (
    .core_clk, .arst_n, .clkEn, .glowBtn, .crankBtn, .panelOnBtn,
    .panelOffBtn, .coolantIn(pins[0]), .leakIn(pins[1]), .lubeIn(pins[2]),
    .alternatorOutputAlarmIn(pins[3]), .coilIn(pins[4]), .chargeSenseIn,
    .glowWithCrankStrap, .excitationSourceStrap,
    .coolantPolarityStrap(pol[0]), .leakPolarityStrap(pol[1]),
    .lubePolarityStrap(pol[2]), .altAlarmPolarityStrap(pol[3]),
    .coilPolarityStrap(pol[4]), .leakSeverityStrap, .altAlarmSeverityStrap,
    .chargePolarityStrapA, .chargePolarityStrapB, .glowRelay, .fuelRelay,
    .crankRelay, .excitationOn, .coolantRedLed, .leakRedLed, .leakYellowLed,
    .lubeRedLed, .altRedLed, .altYellowLed, .coilRedLed, .chargeOkLed,
    .chargeFaultLed, .standbyLed, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .irq);
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // Outputs are read at the edge, before that edge's updates land
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    tick(1);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    tick(1);
    regRd <= 1'b0;
    tick(1);
    chk(regRdata, e);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    tick(20);
    arst_n <= 1'b1;
    tick(2);
    crankBtn <= 1'b1;
    tick(5);
    chk(crankRelay, 0);
    chk(fuelRelay, 0);
    crankBtn <= 1'b0;
    panelOnBtn <= 1'b1;
    tick(4);
    panelOnBtn <= 1'b0;
    tick(4);
    chk(standbyLed, 1);
    rd(`GPFL_OFS_LIVE, 16'h0440);
    rd(`GPFL_OFS_MASK, {10'h000, `GPFL_RST_MASK});
    wr(`GPFL_OFS_MASK, 16'h003f);
    rd(`GPFL_OFS_MASK, 16'h003f);
    $display("panel on test done");
    // A held button must not reach the relay while the enable is low
    clkEn <= 1'b0;
    crankBtn <= 1'b1;
    tick(6);
    chk({crankRelay, fuelRelay, standbyLed}, 3'b011);
    clkEn <= 1'b1;
    crankBtn <= 1'b0;
    tick(5);
    chk(crankRelay, 0);
    $display("clock enable test done");
    for (int s = 0; s < 2; s++) begin
      glowWithCrankStrap <= s[0];
      glowBtn <= 1'b1;
      tick(4);
      chk(glowRelay, 1);
      chk(crankRelay, 0);
      glowBtn <= 1'b0;
      crankBtn <= 1'b1;
      tick(3);
      chk(crankRelay, 0);
      tick(1);
      chk({crankRelay, glowRelay, fuelRelay}, {2'b10 | s[0], 1'b1});
      crankBtn <= 1'b0;
      tick(4);
      chk({crankRelay, glowRelay}, 0);
    end
    $display("button test done");
    // Odd inputs use the closing-contact strap setting
    for (int i = 0; i < 5; i++) begin
      pol[i] <= i[0];
      tick(4);
      fault[i] <= 1'b1;
      tick(i == 2 ? LG : SH);
      chk(red[i], 0);
      tick(6);
      chk({red[i], fuelRelay, irq}, 3'b101);
      rd(`GPFL_OFS_STATUS, 16'h0001 << i);
      crankBtn <= 1'b1;
      tick(4);
      chk(fuelRelay, 1);
      crankBtn <= 1'b0;
      wr(`GPFL_OFS_STATUS, 16'h0001 << i);
      tick(1);
      chk(irq, 0);
      fault[i] <= 1'b0;
      tick(5);
      chk({red[i], fuelRelay}, 2'b01);
    end
    $display("fault test done");
    wr(`GPFL_OFS_MASK, 16'h0001);
    leakSeverityStrap <= 1'b1;
    altAlarmSeverityStrap <= 1'b1;
    fault <= 5'h0a;
    tick(SH + 6);
    chk({leakYellowLed, altYellowLed, red}, 16'h0060);
    chk({fuelRelay, irq}, 2'b10);
    rd(`GPFL_OFS_STATUS, 16'h000a);
    rd(4'hc, 16'h0000);
    wr(`GPFL_OFS_STATUS, 16'h000a);
    fault <= 5'h00;
    chargeSenseIn <= 1'b1;
    tick(5);
    chk({chargeOkLed, chargeFaultLed}, 2'b01);
    chargePolarityStrapA <= 1'b1;
    chargePolarityStrapB <= 1'b1;
    tick(5);
    chk({chargeOkLed, chargeFaultLed}, 2'b10);
    $display("strap test done");
    for (int f = 0; f < 2; f++) begin
      fault[2] <= f[0];
      tick(LG + 6);
      for (int c = 0; c < 4; c++) begin
        excitationSourceStrap <= c[1:0];
        tick(5);
        chk(excitationOn, (c == 2) || (c == 1 && f == 0));
      end
    end
    $display("excitation test done");
    fault[2] <= 1'b0;
    crankBtn <= 1'b1;
    tick(4);
    panelOffBtn <= 1'b1;
    tick(6);
    chk({glowRelay, fuelRelay, crankRelay, standbyLed}, 0);
    panelOffBtn <= 1'b0;
    crankBtn <= 1'b0;
    rd(`GPFL_OFS_LIVE, 16'h0000);
    $display("panel off test done");
    results();
  end
endmodule // gpfl_panel_test
`default_nettype wire
